// file: rtl/omc_ctrl.sv
// Top of the optical module control and status block
`timescale 1ns/1ps
module omc_ctrl import omc_pkg::*; #(
	parameter int INIT_CYCLES = T_INIT_CYC,
	parameter int RESET_CYCLES = T_RESET_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tx_disable_pin,
	input wire logic laser_fault_raw,
	input wire logic rx_signal_lost_raw,
	input wire logic scl_pin,
	input wire logic sda_pin_i,
	output logic sda_pin_o,
	output logic sda_pin_oe,
	output logic presence_pin_o,
	output logic presence_pin_oe,
	input wire logic [15:0] temp_mon,
	input wire logic [15:0] vcc_mon,
	input wire logic [15:0] bias_mon,
	input wire logic [15:0] txpwr_mon,
	input wire logic [15:0] rxpwr_mon,
	input wire logic cal_external,
	output logic laser_en,
	output logic laser_fault_flag,
	output logic optical_signal_absent_flag,
	output logic init_done
);

	// ========================================================================
	// Reset release through two flip-flops
	logic rst_s1_ff, rst_n_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// ========================================================================
	// Pin synchronisers, one lane per outside input except cal_external and the monitor buses
	logic [SY_N-1:0] sy_raw, sy_s1_ff, sy_s2_ff;
	logic dis_s, flt_s, los_s;

	assign sy_raw[SY_DIS] = tx_disable_pin;
	assign sy_raw[SY_FLT] = laser_fault_raw;
	assign sy_raw[SY_LOS] = rx_signal_lost_raw;
	assign sy_raw[SY_SCL] = scl_pin;
	assign sy_raw[SY_SDA] = sda_pin_i;

	for (genvar i = 0; i < SY_N; i++) begin : g_sync
		// Idle lines rest high; shutdown rests high so the laser stays off
		always_ff @(posedge clk or negedge rst_n_ff) begin
			if (!rst_n_ff) begin
				sy_s1_ff[i] <= 1'b1;
				sy_s2_ff[i] <= 1'b1;
			end else begin
				sy_s1_ff[i] <= sy_raw[i];
				sy_s2_ff[i] <= sy_s1_ff[i];
			end
		end
	end

	assign dis_s = sy_s2_ff[SY_DIS];
	assign flt_s = sy_s2_ff[SY_FLT];
	assign los_s = sy_s2_ff[SY_LOS];

	// ========================================================================
	// Initialisation timer, shutdown hold counter, fault latch and outputs
	logic [31:0] init_cnt_ff, nxt_init_cnt;
	logic [31:0] hold_cnt_ff, nxt_hold_cnt;
	logic init_done_ff, nxt_init_done;
	logic dis_prev_ff, nxt_dis_prev;
	logic fault_ff, nxt_fault;
	logic laser_en_ff, nxt_laser_en;
	logic los_ff, nxt_los;
	logic fault_clear;

	// Releasing shutdown after a long enough hold clears the latched fault
	assign fault_clear = dis_prev_ff && !dis_s && (hold_cnt_ff >= 32'(RESET_CYCLES)); // see (RULE_05)

	always_comb begin
		nxt_init_cnt = init_cnt_ff;
		nxt_init_done = init_done_ff;
		if (!init_done_ff) begin
			if (init_cnt_ff >= 32'(INIT_CYCLES - 1)) begin
				nxt_init_done = 1'b1; // see (RULE_03)
			end else begin
				nxt_init_cnt = init_cnt_ff + 32'h1;
			end
		end
		nxt_dis_prev = dis_s;
		// Hold time saturates so a long shutdown cannot wrap back below the limit
		if (!dis_s) begin
			nxt_hold_cnt = 32'h0;
		end else if (hold_cnt_ff < 32'(RESET_CYCLES)) begin
			nxt_hold_cnt = hold_cnt_ff + 32'h1;
		end else begin
			nxt_hold_cnt = hold_cnt_ff;
		end
		// Fault flag: cleared through init, set wins over clear
		nxt_fault = fault_ff;
		if (!init_done_ff) begin
			nxt_fault = 1'b0; // see (RULE_03)
		end else if (flt_s) begin
			nxt_fault = 1'b1; // see (RULE_04) (RULE_09) (RULE_15)
		end else if (fault_clear) begin
			nxt_fault = 1'b0; // see (RULE_15)
		end
		// Laser follows shutdown at once, and is held off by init or fault
		nxt_laser_en = init_done_ff && !dis_s && !nxt_fault; // see (RULE_01) (RULE_02) (RULE_10)
		nxt_los = los_s; // see (RULE_06) (RULE_07) (RULE_13)
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			init_cnt_ff <= 32'h0;
			init_done_ff <= 1'b0;
			hold_cnt_ff <= 32'h0;
			dis_prev_ff <= 1'b1;
			fault_ff <= 1'b0;
			laser_en_ff <= 1'b0;
			los_ff <= 1'b1;
		end else begin
			init_cnt_ff <= nxt_init_cnt;
			init_done_ff <= nxt_init_done;
			hold_cnt_ff <= nxt_hold_cnt;
			dis_prev_ff <= nxt_dis_prev;
			fault_ff <= nxt_fault;
			laser_en_ff <= nxt_laser_en;
			los_ff <= nxt_los;
		end
	end

	// ========================================================================
	// Pin drive registers: presence pulled to ground, serial data open drain
	logic pres_oe_ff, sda_oe_ff, zero_ff;
	logic twi_oe;

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			pres_oe_ff <= 1'b1;
			sda_oe_ff <= 1'b0;
			zero_ff <= 1'b0;
		end else begin
			pres_oe_ff <= 1'b1; // see (RULE_11)
			sda_oe_ff <= twi_oe;
			zero_ff <= 1'b0;
		end
	end

	// ========================================================================
	// Diagnostic byte store read by the serial slave
	omc_diag_if dif ();
	logic [7:0] status_byte;

	assign status_byte = {3'h0, init_done_ff, dis_s, los_ff, fault_ff, cal_external};

	always_comb begin
		unique case (dif.ptr) // see (RULE_14)
			MAP_TEMP: dif.rd_data = temp_mon[15:8];
			MAP_TEMP + 8'h01: dif.rd_data = temp_mon[7:0];
			MAP_VCC: dif.rd_data = vcc_mon[15:8];
			MAP_VCC + 8'h01: dif.rd_data = vcc_mon[7:0];
			MAP_BIAS: dif.rd_data = bias_mon[15:8];
			MAP_BIAS + 8'h01: dif.rd_data = bias_mon[7:0];
			MAP_TXPWR: dif.rd_data = txpwr_mon[15:8];
			MAP_TXPWR + 8'h01: dif.rd_data = txpwr_mon[7:0];
			MAP_RXPWR: dif.rd_data = rxpwr_mon[15:8];
			MAP_RXPWR + 8'h01: dif.rd_data = rxpwr_mon[7:0];
			MAP_STATUS: dif.rd_data = status_byte;
			default: dif.rd_data = MAP_FILL;
		endcase
	end

	omc_twi_slave u_twi (
		.clk (clk),
		.rst_n (rst_n_ff),
		.scl_s (sy_s2_ff[SY_SCL]),
		.sda_s (sy_s2_ff[SY_SDA]),
		.dif (dif),
		.sda_oe (twi_oe)
	); // see (RULE_12)

	// ========================================================================
	// Output ports
	assign laser_en = laser_en_ff;
	assign laser_fault_flag = fault_ff;
	assign optical_signal_absent_flag = los_ff;
	assign init_done = init_done_ff;
	assign presence_pin_o = zero_ff;
	assign presence_pin_oe = pres_oe_ff;
	assign sda_pin_o = zero_ff;
	assign sda_pin_oe = sda_oe_ff;

	// ========================================================================
	// Checks
	property p_off_on_disable;
		@(posedge clk) disable iff (!rst_n_ff) dis_s |=> !laser_en_ff;
	endproperty
	a_off_on_disable: assert property (p_off_on_disable) else $error("laser not off after shutdown"); // see (RULE_02)

	property p_on_after_release;
		@(posedge clk) disable iff (!rst_n_ff)
			($fell(dis_s) && init_done_ff && !fault_ff && !flt_s) ##1 (!dis_s && !flt_s) |-> laser_en_ff;
	endproperty
	a_on_after_release: assert property (p_on_after_release) else $error("laser not restored"); // see (RULE_01)

	property p_init_quiet;
		@(posedge clk) disable iff (!rst_n_ff) !init_done_ff |=> !fault_ff && !laser_en_ff;
	endproperty
	a_init_quiet: assert property (p_init_quiet) else $error("fault or laser active during init"); // see (RULE_03)

	property p_init_time;
		@(posedge clk) disable iff (!rst_n_ff) $rose(init_done_ff) |-> init_cnt_ff == 32'(INIT_CYCLES - 1);
	endproperty
	a_init_time: assert property (p_init_time) else $error("init length wrong"); // see (RULE_03)

	property p_fault_raise;
		@(posedge clk) disable iff (!rst_n_ff) (flt_s && init_done_ff) |=> fault_ff ##1 !laser_en_ff;
	endproperty
	a_fault_raise: assert property (p_fault_raise) else $error("fault flag not raised"); // see (RULE_04)

	property p_fault_latch;
		@(posedge clk) disable iff (!rst_n_ff) (fault_ff && !fault_clear) |=> fault_ff;
	endproperty
	a_fault_latch: assert property (p_fault_latch) else $error("fault flag dropped without reset"); // see (RULE_15)

	property p_fault_short_hold;
		@(posedge clk) disable iff (!rst_n_ff) (fault_ff && $fell(dis_s) && hold_cnt_ff < 32'(RESET_CYCLES)) |-> ##1 fault_ff;
	endproperty
	a_fault_short_hold: assert property (p_fault_short_hold) else $error("short shutdown cleared fault"); // see (RULE_15)

	property p_los_set;
		@(posedge clk) disable iff (!rst_n_ff) los_s |=> optical_signal_absent_flag;
	endproperty
	a_los_set: assert property (p_los_set) else $error("signal-absent flag not raised"); // see (RULE_06)

	property p_los_clear;
		@(posedge clk) disable iff (!rst_n_ff) !los_s |=> !optical_signal_absent_flag;
	endproperty
	a_los_clear: assert property (p_los_clear) else $error("signal-absent flag not cleared"); // see (RULE_07)

	property p_presence;
		@(posedge clk) disable iff (!rst_n_ff) presence_pin_oe && !presence_pin_o;
	endproperty
	a_presence: assert property (p_presence) else $error("presence pin not grounded"); // see (RULE_11)

	property p_status_byte;
		@(posedge clk) disable iff (!rst_n_ff) dif.ptr == MAP_STATUS |-> dif.rd_data[ST_FAULT] == fault_ff;
	endproperty
	a_status_byte: assert property (p_status_byte) else $error("status byte wrong"); // see (RULE_14)

	// ========================================================================
	// Pin-to-output timing, fault latch corners and status layout
	property p_off_pin;
		@(posedge clk) disable iff (!rst_n_ff) $rose(sy_raw[SY_DIS]) |-> ##[1:4] !laser_en_ff;
	endproperty
	a_off_pin: assert property (p_off_pin) else $error("laser slow to turn off"); // see (RULE_02)

	property p_fault_pin;
		@(posedge clk) disable iff (!rst_n_ff) ($rose(sy_raw[SY_FLT]) && init_done_ff) |-> ##[1:4] fault_ff;
	endproperty
	a_fault_pin: assert property (p_fault_pin) else $error("fault flag slow"); // see (RULE_04)

	property p_los_on_pin;
		@(posedge clk) disable iff (!rst_n_ff) $rose(sy_raw[SY_LOS]) |-> ##[1:4] los_ff;
	endproperty
	a_los_on_pin: assert property (p_los_on_pin) else $error("signal-absent flag slow to rise"); // see (RULE_06)

	property p_los_off_pin;
		@(posedge clk) disable iff (!rst_n_ff) $fell(sy_raw[SY_LOS]) |-> ##[1:4] !los_ff;
	endproperty
	a_los_off_pin: assert property (p_los_off_pin) else $error("signal-absent flag slow to fall"); // see (RULE_07)

	property p_fault_clear;
		@(posedge clk) disable iff (!rst_n_ff) (fault_clear && !flt_s) |=> !fault_ff;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared by long shutdown"); // see (RULE_15)

	property p_fault_set_wins;
		@(posedge clk) disable iff (!rst_n_ff) (fault_clear && flt_s && init_done_ff) |=> fault_ff;
	endproperty
	a_fault_set_wins: assert property (p_fault_set_wins) else $error("clear beat a live fault"); // see (RULE_15)

	// Laser only on when init is over, shutdown was low and no fault is latched
	property p_laser_gate;
		@(posedge clk) disable iff (!rst_n_ff) laser_en_ff |-> init_done_ff && !$past(dis_s) && !fault_ff;
	endproperty
	a_laser_gate: assert property (p_laser_gate) else $error("laser on while held off"); // see (RULE_10)

	property p_init_stays;
		@(posedge clk) disable iff (!rst_n_ff) init_done_ff |=> init_done_ff;
	endproperty
	a_init_stays: assert property (p_init_stays) else $error("init done dropped"); // see (RULE_03)

	property p_status_fields;
		@(posedge clk) disable iff (!rst_n_ff) dif.ptr == MAP_STATUS |-> dif.rd_data[ST_CAL_EXT] == cal_external
			&& dif.rd_data[ST_LOS] == los_ff && dif.rd_data[ST_TXDIS] == dis_s && dif.rd_data[ST_READY] == init_done_ff;
	endproperty
	a_status_fields: assert property (p_status_fields) else $error("status fields misplaced"); // see (RULE_14)

	c_fault_reset: cover property (@(posedge clk) disable iff (!rst_n_ff) fault_ff ##1 fault_clear ##1 !fault_ff);
	c_laser_on: cover property (@(posedge clk) disable iff (!rst_n_ff) $rose(laser_en_ff));
	c_los_cycle: cover property (@(posedge clk) disable iff (!rst_n_ff) $rose(los_ff) ##[1:1000] $fell(los_ff));

endmodule : omc_ctrl

// file: rtl/omc_diag_if.sv
// Interface between the serial slave and the diagnostic byte store
`timescale 1ns/1ps
interface omc_diag_if;
	logic [7:0] ptr;
	logic [7:0] rd_data;
	modport slave (output ptr, input rd_data);
	modport store (input ptr, output rd_data);
endinterface : omc_diag_if

// file: rtl/omc_pkg.sv
// Package of constants for the optical module control and status block
// ============================================================================
// Function
// (RULE_01) Laser output returns within 1 ms after shutdown input is released.
// (RULE_02) Laser output turns off within 10 us after shutdown input is asserted.
// (RULE_03) Initialisation, with fault flag cleared, completes within 300 ms.
// (RULE_04) Laser fault flag rises within 100 us after a laser fault occurs.
// (RULE_05) Host holds shutdown high at least 10 us to reset a fault.
// (RULE_06) Signal-absent flag rises within 100 us after received power is lost.
// (RULE_07) Signal-absent flag falls within 100 us after received power returns.
// (RULE_08) Host runs the serial clock at no more than 400 kHz; the bench host model runs it time-scaled at a 64 ns period.
// (RULE_09) Fault flag is low in normal operation, high on any laser fault.
// (RULE_10) Transmitter on when shutdown low; off when high or left open.
// (RULE_11) Presence pin is held at ground by the module.
// (RULE_12) Identification data moves over two-wire serial clock and data pins.
// (RULE_13) Signal-absent flag high when signal lost, low in normal operation.
// (RULE_14) Serial interface reports rx power, tx power, bias, supply, temperature.
// (RULE_15) Fault flag stays latched until shutdown toggle or power cycle.
package omc_pkg;

	// ========================================================================
	// Clock and documented times
	localparam int CLK_MHZ = 125;
	localparam int T_ON_MS = 1;
	localparam int T_OFF_US = 10;
	localparam int T_INIT_MS = 300;
	localparam int T_FAULT_US = 100;
	localparam int T_RESET_US = 10;
	localparam int T_LOS_US = 100;
	localparam int F_SCL_MAX_KHZ = 400;

	// Derived cycle counts (least time rounded up, longest rounded down)
	localparam int T_RESET_CYC = (T_RESET_US * CLK_MHZ * 1000 + 999) / 1000;
	localparam int T_OFF_CYC = T_OFF_US * CLK_MHZ;
	localparam int T_INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;

	// ========================================================================
	// Synchroniser lanes for pins from outside the clock domain
	localparam int SY_N = 5;
	localparam int SY_DIS = 0;
	localparam int SY_FLT = 1;
	localparam int SY_LOS = 2;
	localparam int SY_SCL = 3;
	localparam int SY_SDA = 4;

	// ========================================================================
	// Serial slave address and diagnostic byte map
	localparam logic [6:0] TWI_ADDR = 7'h2a;
	localparam logic [7:0] MAP_TEMP = 8'h00;
	localparam logic [7:0] MAP_VCC = 8'h02;
	localparam logic [7:0] MAP_BIAS = 8'h04;
	localparam logic [7:0] MAP_TXPWR = 8'h06;
	localparam logic [7:0] MAP_RXPWR = 8'h08;
	localparam logic [7:0] MAP_STATUS = 8'h0a;
	localparam logic [7:0] MAP_FILL = 8'h00;

	// Status byte field positions
	localparam int ST_CAL_EXT = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_LOS = 2;
	localparam int ST_TXDIS = 3;
	localparam int ST_READY = 4;

	// Serial slave states
	typedef enum logic [3:0] {
		TW_IDLE, TW_DEV, TW_DEV_ACK, TW_PTR, TW_PTR_ACK, TW_TX, TW_TX_ACK, TW_TX_LOAD, TW_WAIT
	} omc_tw_state_t;

endpackage : omc_pkg

// file: rtl/omc_twi_slave.sv
// Two-wire serial slave that reads the diagnostic byte store
`timescale 1ns/1ps
module omc_twi_slave import omc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_s,
	input wire logic sda_s,
	omc_diag_if.slave dif,
	output logic sda_oe
);

	omc_tw_state_t state_ff, nxt_state;
	logic prev_scl_ff, prev_sda_ff, rw_ff, nxt_rw, sda_oe_ff, nxt_sda_oe;
	logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr;
	logic [3:0] cnt_ff, nxt_cnt;
	logic start, stop, rise, fall;

	// ========================================================================
	// Bus conditions seen on the synchronised lines
	assign start = prev_scl_ff & scl_s & prev_sda_ff & ~sda_s;
	assign stop = prev_scl_ff & scl_s & ~prev_sda_ff & sda_s;
	assign rise = ~prev_scl_ff & scl_s;
	assign fall = prev_scl_ff & ~scl_s;

	// Next state; data is sampled on rising and driven after falling clock
	always_comb begin
		nxt_state = state_ff;
		nxt_rw = rw_ff;
		nxt_sh = sh_ff;
		nxt_ptr = ptr_ff;
		nxt_cnt = cnt_ff;
		nxt_sda_oe = sda_oe_ff;
		if (start) begin // see (RULE_12)
			nxt_state = TW_DEV;
			nxt_cnt = 4'h0;
			nxt_sda_oe = 1'b0;
		end else if (stop) begin
			nxt_state = TW_IDLE;
			nxt_sda_oe = 1'b0;
		end else begin
			unique case (state_ff)
				TW_IDLE, TW_WAIT: begin
				end
				TW_DEV: begin
					if (rise) begin
						nxt_sh = {sh_ff[6:0], sda_s};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (fall && cnt_ff == 4'h8) begin
						if (sh_ff[7:1] == TWI_ADDR) begin
							nxt_rw = sh_ff[0];
							nxt_sda_oe = 1'b1; // Acknowledge own address
							nxt_state = TW_DEV_ACK;
						end else begin
							nxt_state = TW_WAIT;
						end
					end
				end
				TW_DEV_ACK: begin
					if (fall) begin
						if (rw_ff) begin
							nxt_sh = dif.rd_data;
							nxt_sda_oe = ~dif.rd_data[7];
							nxt_cnt = 4'h1;
							nxt_state = TW_TX;
						end else begin
							nxt_sda_oe = 1'b0;
							nxt_cnt = 4'h0;
							nxt_state = TW_PTR;
						end
					end
				end
				TW_PTR: begin
					if (rise) begin
						nxt_sh = {sh_ff[6:0], sda_s};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (fall && cnt_ff == 4'h8) begin
						nxt_ptr = sh_ff;
						nxt_sda_oe = 1'b1;
						nxt_state = TW_PTR_ACK;
					end
				end
				TW_PTR_ACK: begin
					if (fall) begin
						nxt_sda_oe = 1'b0;
						nxt_state = TW_WAIT; // Further written bytes are not taken
					end
				end
				TW_TX: begin
					if (fall) begin
						if (cnt_ff == 4'h8) begin
							nxt_sda_oe = 1'b0;
							nxt_state = TW_TX_ACK;
						end else begin
							nxt_sda_oe = ~sh_ff[6];
							nxt_sh = {sh_ff[6:0], 1'b0};
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				TW_TX_ACK: begin
					if (rise) begin
						if (!sda_s) begin
							nxt_ptr = ptr_ff + 8'h01;
							nxt_state = TW_TX_LOAD;
						end else begin
							nxt_state = TW_WAIT; // Master ends the read
						end
					end
				end
				TW_TX_LOAD: begin
					if (fall) begin
						nxt_sh = dif.rd_data;
						nxt_sda_oe = ~dif.rd_data[7];
						nxt_cnt = 4'h1;
						nxt_state = TW_TX;
					end
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= TW_IDLE;
			prev_scl_ff <= 1'b1;
			prev_sda_ff <= 1'b1;
			rw_ff <= 1'b0;
			sh_ff <= 8'h00;
			ptr_ff <= 8'h00;
			cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			prev_scl_ff <= scl_s;
			prev_sda_ff <= sda_s;
			rw_ff <= nxt_rw;
			sh_ff <= nxt_sh;
			ptr_ff <= nxt_ptr;
			cnt_ff <= nxt_cnt;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	assign dif.ptr = ptr_ff;
	assign sda_oe = sda_oe_ff;

	// ========================================================================
	// Checks on the serial line
	property p_tw_oe_scl_low;
		@(posedge clk) disable iff (!rst_n) $changed(sda_oe_ff) |-> !prev_scl_ff || (start || stop);
	endproperty
	a_tw_oe_scl_low: assert property (p_tw_oe_scl_low) else $error("data line changed with clock high"); // see (RULE_12)

	property p_tw_start;
		@(posedge clk) disable iff (!rst_n) start |=> (state_ff == TW_DEV) && !sda_oe_ff && (cnt_ff == 4'h0);
	endproperty
	a_tw_start: assert property (p_tw_start) else $error("start condition not taken"); // see (RULE_12)

	property p_tw_addr_ack;
		@(posedge clk) disable iff (!rst_n)
			(state_ff == TW_DEV && fall && !start && !stop && cnt_ff == 4'h8 && sh_ff[7:1] == TWI_ADDR)
			|=> sda_oe_ff && state_ff == TW_DEV_ACK;
	endproperty
	a_tw_addr_ack: assert property (p_tw_addr_ack) else $error("own address not acknowledged"); // see (RULE_12)

	c_tw_read: cover property (@(posedge clk) disable iff (!rst_n) state_ff == TW_TX_ACK ##[1:1000] state_ff == TW_TX_LOAD);
	c_tw_ptr: cover property (@(posedge clk) disable iff (!rst_n) state_ff == TW_PTR_ACK);

endmodule : omc_twi_slave

// file: tb/omc_ctrl_bench.sv
// Self-checking bench for the optical module control and status block
`timescale 1ns/1ps
module omc_ctrl_bench import omc_pkg::*;;
	localparam int INIT = 100;
	localparam int RCYC = 20;
	logic clk, rst_b, laser_fault_raw, rx_signal_lost_raw, cal_external, dis_val, dis_oe;
	logic scl_pin, sda_line, sda_pin_o, sda_pin_oe, presence_pin_o, presence_pin_oe, mod_present;
	logic tx_disable_pin, laser_en, laser_fault_flag, optical_signal_absent_flag, init_done;
	logic [15:0] mon [0:4];
	logic [3:0] obs;
	logic [7:0] exp_b [0:11];
	int err_total = 0;
	int num_checks = 0;
	// Observed levels: 3 init, 2 laser, 1 fault, 0 absent
	assign obs = {init_done, laser_en, laser_fault_flag, optical_signal_absent_flag};
	// ========================================================================
	// Design, host model and clock
	omc_ctrl #(.INIT_CYCLES(INIT), .RESET_CYCLES(RCYC)) uut (.clk(clk), .rst_b(rst_b),
		.tx_disable_pin(tx_disable_pin), .laser_fault_raw(laser_fault_raw),
		.rx_signal_lost_raw(rx_signal_lost_raw), .scl_pin(scl_pin), .sda_pin_i(sda_line),
		.sda_pin_o(sda_pin_o), .sda_pin_oe(sda_pin_oe), .presence_pin_o(presence_pin_o),
		.presence_pin_oe(presence_pin_oe), .temp_mon(mon[0]), .vcc_mon(mon[1]), .bias_mon(mon[2]),
		.txpwr_mon(mon[3]), .rxpwr_mon(mon[4]), .cal_external(cal_external), .laser_en(laser_en),
		.laser_fault_flag(laser_fault_flag), .optical_signal_absent_flag(optical_signal_absent_flag),
		.init_done(init_done));
	omc_host_model host (.scl_pin(scl_pin), .sda_line(sda_line), .sda_pin_o(sda_pin_o),
		.sda_pin_oe(sda_pin_oe), .presence_pin_o(presence_pin_o), .presence_pin_oe(presence_pin_oe),
		.mod_present(mod_present), .dis_val(dis_val), .dis_oe(dis_oe), .tx_disable_pin(tx_disable_pin));
	initial clk = 1'b0;
	always #4 clk = ~clk;
	// ========================================================================
	// Shared tasks
	task chk(input string name, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// Bounded wait for one observed level, then compare
	task wait_for(input int k, input logic v, input int lim, input string name);
		int c;
		c = 0;
		while (obs[k] !== v && c < lim) begin
			step(1);
			c++;
		end
		chk(name, {15'h0000, v}, {15'h0000, obs[k]});
	endtask : wait_for
	task pulse(input int n);
		dis_val = 1'b1;
		step(n);
		dis_val = 1'b0;
	endtask : pulse
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	// Watchdog, far beyond the expected run of about two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out();
	end
	// ========================================================================
	// Test sequence
	initial begin
		rst_b = 1'b0;
		{laser_fault_raw, rx_signal_lost_raw, cal_external, dis_val} = 4'h0;
		dis_oe = 1'b1;
		mon = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h7081, 16'h92a3};
		step(2);
		rst_b = 1'b1;
		step(3);
		chk("present", 16'h0001, {15'h0000, mod_present});
		laser_fault_raw = 1'b1;
		step(10);
		chk("early fault", 16'h0000, {15'h0000, laser_fault_flag});
		chk("early laser", 16'h0000, {15'h0000, laser_en});
		laser_fault_raw = 1'b0;
		wait_for(3, 1'b1, INIT + 10, "init_done");
		wait_for(2, 1'b1, 10, "laser on");
		$display("test reset done");
		dis_val = 1'b1;
		wait_for(2, 1'b0, T_OFF_CYC, "laser off");
		dis_val = 1'b0;
		wait_for(2, 1'b1, 1000, "laser restored");
		dis_oe = 1'b0;
		wait_for(2, 1'b0, T_OFF_CYC, "open pin");
		dis_oe = 1'b1;
		wait_for(2, 1'b1, 1000, "laser restored");
		$display("test shutdown done");
		laser_fault_raw = 1'b1;
		wait_for(1, 1'b1, T_FAULT_US * CLK_MHZ, "fault flag");
		chk("laser in fault", 16'h0000, {15'h0000, laser_en});
		laser_fault_raw = 1'b0;
		step(20);
		chk("fault latched", 16'h0001, {15'h0000, laser_fault_flag});
		pulse(RCYC - 6);
		step(10);
		chk("short pulse", 16'h0001, {15'h0000, laser_fault_flag});
		pulse(RCYC + 4);
		wait_for(1, 1'b0, 10, "fault cleared");
		wait_for(2, 1'b1, 1000, "laser after clear");
		laser_fault_raw = 1'b1;
		wait_for(1, 1'b1, T_FAULT_US * CLK_MHZ, "fault again");
		pulse(RCYC + 4);
		step(10);
		chk("fault persists", 16'h0001, {15'h0000, laser_fault_flag});
		laser_fault_raw = 1'b0;
		pulse(RCYC + 4);
		wait_for(1, 1'b0, 10, "fault cleared");
		$display("test fault done");
		chk("absent idle", 16'h0000, {15'h0000, optical_signal_absent_flag});
		rx_signal_lost_raw = 1'b1;
		wait_for(0, 1'b1, T_LOS_US * CLK_MHZ, "absent set");
		rx_signal_lost_raw = 1'b0;
		wait_for(0, 1'b0, T_LOS_US * CLK_MHZ, "absent clear");
		$display("test signal absent done");
		rx_signal_lost_raw = 1'b1;
		wait_for(0, 1'b1, T_LOS_US * CLK_MHZ, "absent set");
		for (int i = 0; i < 5; i++) begin
			exp_b[2 * i] = mon[i][15:8];
			exp_b[2 * i + 1] = mon[i][7:0];
		end
		exp_b[10] = 8'h14;
		exp_b[11] = MAP_FILL;
		host.read_regs(TWI_ADDR, MAP_TEMP, 12);
		chk("ack", 16'h0001, {15'h0000, host.acked});
		for (int i = 0; i < 12; i++) begin
			chk("map byte", {8'h00, exp_b[i]}, {8'h00, host.rx_buf[i]});
		end
		{cal_external, rx_signal_lost_raw, laser_fault_raw, dis_val} = 4'hb;
		step(20);
		host.read_regs(TWI_ADDR, MAP_STATUS, 1);
		chk("status", 16'h001b, {8'h00, host.rx_buf[0]});
		host.read_regs(TWI_ADDR ^ 7'h01, MAP_TEMP, 1);
		chk("foreign addr", 16'h0000, {15'h0000, host.acked});
		$display("test serial done");
		close_out();
	end
endmodule : omc_ctrl_bench

// file: tb/omc_host_model.sv
// Host board model: pull-ups, shutdown drive and two-wire serial master
`timescale 1ns/1ps
module omc_host_model (
	output logic scl_pin,
	output logic sda_line,
	input wire logic sda_pin_o,
	input wire logic sda_pin_oe,
	input wire logic presence_pin_o,
	input wire logic presence_pin_oe,
	output logic mod_present,
	input wire logic dis_val,
	input wire logic dis_oe,
	output logic tx_disable_pin
);
	// ========================================================================
	// Pin resolution
	logic sda_m_oe;
	logic acked;
	logic [7:0] rx_buf [0:15];
	// Open-drain lines rest at the pull-up level unless someone pulls low
	assign sda_line = sda_pin_oe ? sda_pin_o : (sda_m_oe ? 1'b0 : 1'b1);
	assign mod_present = presence_pin_oe ? ~presence_pin_o : 1'b0;
	assign tx_disable_pin = dis_oe ? dis_val : 1'b1;
	// Idle bus
	initial begin
		scl_pin = 1'b1;
		sda_m_oe = 1'b0;
		acked = 1'b0;
	end
	// ========================================================================
	// Bit level, all steps multiples of the 8 ns system period
	// Serial clock is time-scaled to a 64 ns period; the slave only follows edges
	task bit_out(input logic b);
		#16 sda_m_oe = ~b;
		#16 scl_pin = 1'b1;
		#32 scl_pin = 1'b0;
	endtask : bit_out
	task bit_in(output logic b);
		#16 sda_m_oe = 1'b0;
		#16 scl_pin = 1'b1;
		#24 b = sda_line;
		#8 scl_pin = 1'b0;
	endtask : bit_in
	// Start or repeated start: data falls while clock is high
	task start_c;
		#16 sda_m_oe = 1'b0;
		#16 scl_pin = 1'b1;
		#32 sda_m_oe = 1'b1;
		#32 scl_pin = 1'b0;
	endtask : start_c
	task stop_c;
		#16 sda_m_oe = 1'b1;
		#16 scl_pin = 1'b1;
		#32 sda_m_oe = 1'b0;
		#32;
	endtask : stop_c
	// ========================================================================
	// Byte level, most significant bit first
	task wr_byte(input logic [7:0] v, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_out(v[i]);
		end
		bit_in(b);
		ack = ~b;
	endtask : wr_byte
	task rd_byte(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			bit_in(v[i]);
		end
		bit_out(last);
	endtask : rd_byte
	// Pointer write, repeated start, then n bytes read into rx_buf
	task read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n);
		logic a0;
		logic a1;
		logic a2;
		start_c();
		wr_byte({dev, 1'b0}, a0);
		acked = a0;
		if (!a0) begin
			stop_c();
			return;
		end
		wr_byte(ptr, a1);
		start_c();
		wr_byte({dev, 1'b1}, a2);
		for (int i = 0; i < n; i++) begin
			rd_byte(i == n - 1, rx_buf[i]);
		end
		stop_c();
		acked = a1 & a2;
	endtask : read_regs
endmodule : omc_host_model
